// *** logic/puas_init_core.sv ***
// Power-up initialisation and bus-address selection core.
// Holds internal reset until supplies and oscillator are good, loads the
// configuration memory, samples the address strap once, forms the bus
// addresses and gates power conversion.
// Assumes a config memory that answers one word per request, a strap
// converter with a start/done handshake, and a bus engine that asks for
// address matches and forwards register writes.
`timescale 1ns/1ps
`default_nettype none
module puas_init_core
    import puas_pkg::*;
#(
    parameter int CFG_WORDS = 16 // Configuration words loaded at power-up
)
(
    input  wire logic       mclk_in,             // 200 MHz clock
    input  wire logic       reset_n_in,          // Sync reset, active low
    input  wire logic       vcc_good_in,         // Bias supply good
    input  wire logic       core_rail_good_in,   // Core rail good
    input  wire logic       osc_stable_in,       // Oscillator stable
    output logic            cfg_rd_req_out,      // Config word request
    output logic      [3:0] cfg_rd_index_out,    // Config word index
    input  wire logic       cfg_rd_valid_in,     // Config word present
    input  wire logic [7:0] cfg_rd_data_in,      // Config word value
    output logic            adc_start_out,       // Strap conversion start
    input  wire logic       adc_done_in,         // Strap conversion done
    input  wire logic [9:0] adc_code_in,         // Strap reading
    input  wire puas_wr_s   wr_in,               // Register write request
    input  wire logic [3:0] rd_index_in,         // Register read index
    output logic      [7:0] rd_data_out,         // Register read value
    input  wire puas_addr_s addr_in,             // Address match request
    output logic            addr_ack_out,        // Address acknowledged
    output logic            wr_refused_out,      // Write not stored
    input  wire logic       enable_input_pin_in, // Enable above threshold
    input  wire logic       bus_supply_ok_in,    // Bus supply above UVLO
    output logic            internal_reset_n_out,// Internal reset, low
    output logic            init_done_out,       // Initialisation finished
    output logic            analog_mode_out,     // Analog mode selected
    output logic      [2:0] pins_analog_out,     // Comm pins to analog use
    output logic      [6:0] i2c_address_out,     // Computed I2C address
    output logic      [6:0] mgmt_address_out,    // Computed mgmt address
    output logic      [3:0] addr_offset_out,     // Latched strap offset
    output logic            conv_en_out          // Power conversion enable
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    // Index is four bits and the first three words have fixed meaning.
    if (CFG_WORDS < 3 || CFG_WORDS > 16)
    begin : g_bad_words
        $error("CFG_WORDS must lie between 3 and 16");
    end

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed
    {
        puas_state_e                 st;        // Sequencer state
        logic [3:0]                  idx;       // Load word counter
        logic                        req;       // Config request level
        logic                        adc_start; // Conversion start pulse
        logic                        load_done; // All words copied
        logic                        sampled;   // Strap offset latched
        logic                        analog;    // Analog mode
        logic [3:0]                  offset;    // Latched strap offset
        logic [CFG_WORDS-1:0][7:0]   wreg;      // Working registers
        logic [6:0]                  i2c_addr;  // Computed I2C address
        logic [6:0]                  mgmt_addr; // Computed mgmt address
        logic                        ack;       // Address ack
        logic                        refused;   // Write refused pulse
        logic                        conv_en;   // Conversion enable
        logic                        rst_n_int; // Internal reset
        logic                        init_done; // Init finished
        logic [7:0]                  rd_data;   // Read data
    } puas_core_s;

    puas_core_s r;   // Registered state
    puas_core_s nxt; // Next state

    // ------------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------------
    logic [3:0] strap_offset; // Decoded offset
    logic       strap_float;  // Strap left open

    puas_strap_decode u_strap
    (
        .code_in      (adc_code_in),
        .offset_out   (strap_offset),
        .floating_out (strap_float)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address from a base word and the latched offset; a zero base
    // means the bus is switched off, so the address reads back as zero.
    function automatic logic [6:0] puas_form_addr(input logic [7:0] base,
                                                  input logic [3:0] off);
        logic [6:0] sum;
        sum = 7'(base[PUAS_ADDR_MSB:0] + {3'h0, off});
        return (base[PUAS_ADDR_MSB:0] == PUAS_ADDR_OFF) ? PUAS_ADDR_OFF : sum;
    endfunction : puas_form_addr

    // Index inside the loaded word range.
    function automatic logic puas_in_range(input logic [3:0] index);
        return ({1'b0, index} < 5'(CFG_WORDS));
    endfunction : puas_in_range

    logic supplies_ok; // Both supplies and oscillator good
    logic sw_override; // Software enable options in force
    logic hw_enable;   // Default four-condition enable

    assign supplies_ok = vcc_good_in & core_rail_good_in & osc_stable_in;
    assign sw_override = !r.analog & r.wreg[PUAS_IDX_EN_OPT][PUAS_EN_OVR_BIT];
    assign hw_enable   = enable_input_pin_in & bus_supply_ok_in
                         & r.load_done & r.sampled;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt           = r;
        nxt.adc_start = 1'b0;
        nxt.refused   = 1'b0;
        nxt.ack       = 1'b0;
        nxt.rst_n_int = supplies_ok;
        if (!supplies_ok)
        begin
            // A supply dip restarts the whole sequence from scratch
            nxt.st        = PUAS_HOLD;
            nxt.idx       = 4'h0;
            nxt.req       = 1'b0;
            nxt.load_done = 1'b0;
            nxt.sampled   = 1'b0;
            nxt.analog    = 1'b0;
        end
        else
        begin
            unique case (r.st)
                PUAS_HOLD:
                begin
                    // Reset released: start the one load cycle
                    nxt.st  = PUAS_LOAD;
                    nxt.idx = 4'h0;
                    nxt.req = 1'b1;
                end
                PUAS_LOAD:
                begin
                    if (cfg_rd_valid_in)
                    begin
                        nxt.wreg[r.idx] = cfg_rd_data_in;
                        if (r.idx == 4'(CFG_WORDS - 1))
                        begin
                            nxt.req       = 1'b0;
                            nxt.load_done = 1'b1;
                            nxt.st        = PUAS_STRAP;
                            nxt.adc_start = 1'b1;
                        end
                        else
                        begin
                            nxt.idx = 4'(r.idx + 4'h1);
                        end
                    end
                end
                PUAS_STRAP:
                begin
                    if (adc_done_in)
                    begin
                        nxt.offset  = strap_offset;
                        nxt.analog  = strap_float;
                        nxt.sampled = 1'b1;
                        nxt.st      = PUAS_RUN;
                    end
                end
                PUAS_RUN:
                begin
                    if (wr_in.valid)
                    begin
                        if (!r.analog && puas_in_range(wr_in.index))
                        begin
                            nxt.wreg[wr_in.index] = wr_in.data;
                        end
                        else
                        begin
                            nxt.refused = 1'b1;
                        end
                    end
                end
                default:
                begin
                    // Illegal code: fall back to the held state
                    nxt.st = PUAS_HOLD;
                end
            endcase
        end
        // Writes outside the run state, or during a supply dip, are
        // refused visibly so the bus engine never loses one silently
        if (wr_in.valid && (r.st != PUAS_RUN || !supplies_ok))
        begin
            nxt.refused = 1'b1;
        end
        nxt.i2c_addr  = r.sampled ? puas_form_addr(r.wreg[PUAS_IDX_I2C_BASE],
                                                   r.offset) : PUAS_ADDR_OFF;
        nxt.mgmt_addr = r.sampled ? puas_form_addr(r.wreg[PUAS_IDX_MGMT_BASE],
                                                   r.offset) : PUAS_ADDR_OFF;
        if (addr_in.valid && r.st == PUAS_RUN && !r.analog)
        begin
            if (addr_in.mgmt)
            begin
                nxt.ack = (r.mgmt_addr != PUAS_ADDR_OFF)
                          && (addr_in.addr == r.mgmt_addr);
            end
            else
            begin
                nxt.ack = (r.i2c_addr != PUAS_ADDR_OFF)
                          && (addr_in.addr == r.i2c_addr);
            end
        end
        if (sw_override)
        begin
            nxt.conv_en = r.wreg[PUAS_IDX_EN_OPT][PUAS_EN_ON_BIT]
                          & r.load_done & r.sampled;
        end
        else
        begin
            nxt.conv_en = hw_enable;
        end
        nxt.init_done = nxt.load_done & nxt.sampled;
        nxt.rd_data   = puas_in_range(rd_index_in) ? r.wreg[rd_index_in]
                                                   : 8'h00;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            r                           <= '0;
            r.st                        <= PUAS_HOLD;
            r.wreg[PUAS_IDX_I2C_BASE]   <= PUAS_I2C_BASE_RST;
            r.wreg[PUAS_IDX_MGMT_BASE]  <= PUAS_MGMT_BASE_RST;
        end
        else
        begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign cfg_rd_req_out       = r.req;
    assign cfg_rd_index_out     = r.idx;
    assign adc_start_out        = r.adc_start;
    assign rd_data_out          = r.rd_data;
    assign addr_ack_out         = r.ack;
    assign wr_refused_out       = r.refused;
    assign internal_reset_n_out = r.rst_n_int;
    assign init_done_out        = r.init_done;
    assign analog_mode_out      = r.analog;
    assign pins_analog_out      = {3{r.analog}};
    assign i2c_address_out      = r.i2c_addr;
    assign mgmt_address_out     = r.mgmt_addr;
    assign addr_offset_out      = r.offset;
    assign conv_en_out          = r.conv_en;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    rst_hold_a: assert property (!supplies_ok |=> !internal_reset_n_out)
        else $error("internal reset released with supplies not good");

    load_end_a: assert property (
        (r.st == PUAS_LOAD && cfg_rd_valid_in && supplies_ok
         && r.idx == 4'(CFG_WORDS - 1))
        |=> r.load_done && adc_start_out && !cfg_rd_req_out)
        else $error("load did not finish after last word");

    write_take_a: assert property (
        (r.st == PUAS_RUN && supplies_ok && wr_in.valid && !r.analog
         && wr_in.index == 4'h0)
        |=> r.wreg[0] == $past(wr_in.data) && !wr_refused_out)
        else $error("run-time write not stored");

    conv_gate_a: assert property (
        (!sw_override && !(enable_input_pin_in && bus_supply_ok_in
         && r.load_done && r.sampled)) |=> !conv_en_out)
        else $error("conversion enabled without all conditions");

    sw_enable_a: assert property (
        (sw_override && r.wreg[PUAS_IDX_EN_OPT][PUAS_EN_ON_BIT]
         && r.load_done && r.sampled) |=> conv_en_out)
        else $error("software enable ignored");

    zero_nak_a: assert property (
        (addr_in.valid && !addr_in.mgmt && r.i2c_addr == PUAS_ADDR_OFF)
        |=> !addr_ack_out)
        else $error("acknowledged on a disabled bus");

    addr_sum_a: assert property (
        (r.sampled && r.wreg[0][6:0] != 7'h00) ##1 r.sampled
        |-> i2c_address_out == 7'($past(r.wreg[0][6:0]) + $past(r.offset)))
        else $error("I2C address is not base plus offset");

    strap_once_a: assert property (
        (r.st == PUAS_RUN && supplies_ok) |=> $stable(addr_offset_out))
        else $error("strap offset changed after sampling");

    analog_lock_a: assert property (
        (r.st == PUAS_RUN && r.analog && wr_in.valid)
        |=> wr_refused_out && $stable(r.wreg))
        else $error("analog mode register modified");

    done_pair_a: assert property (
        $rose(init_done_out) |-> $past(r.st) == PUAS_STRAP
        && $past(adc_done_in) && $past(r.load_done))
        else $error("init done before load and strap");

endmodule : puas_init_core
`default_nettype wire

// *** logic/puas_pkg.sv ***
// Shared constants, state codes and carrier types for the power-up
// initialisation and bus-address selection block.
// Assumes a single 200 MHz clock domain and synchronous active-low reset.
package puas_pkg;

    // ------------------------------------------------------------------
    // Working register map (index into the loaded configuration words)
    // ------------------------------------------------------------------
    localparam logic [3:0] PUAS_IDX_I2C_BASE  = 4'h0; // I2C base address
    localparam logic [3:0] PUAS_IDX_MGMT_BASE = 4'h1; // Mgmt-bus base address
    localparam logic [3:0] PUAS_IDX_EN_OPT    = 4'h2; // Software enable options

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PUAS_ADDR_MSB    = 6;  // Bases occupy bits 6..0
    localparam int PUAS_EN_OVR_BIT  = 0;  // Software enable overrides pins
    localparam int PUAS_EN_ON_BIT   = 1;  // Software conversion request

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [7:0] PUAS_I2C_BASE_RST  = 8'h10; // Factory I2C base
    localparam logic [7:0] PUAS_MGMT_BASE_RST = 8'h40; // Factory mgmt base
    localparam logic [6:0] PUAS_ADDR_OFF      = 7'h00; // Address disabled

    // ------------------------------------------------------------------
    // Strap converter bands (10-bit codes)
    // ------------------------------------------------------------------
    localparam logic [10:0] PUAS_STRAP_NOM0 = 11'h020; // Nominal of band 0
    localparam logic [10:0] PUAS_STRAP_STEP = 11'h03c; // Band spacing
    localparam logic [10:0] PUAS_STRAP_HALF = 11'h01e; // Half band spacing
    localparam logic [3:0]  PUAS_STRAP_TOP  = 4'hf;    // Highest offset

    // ------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0]
    {
        PUAS_HOLD  = 4'h1, // Internal reset held
        PUAS_LOAD  = 4'h2, // Copying configuration words
        PUAS_STRAP = 4'h4, // Waiting on strap conversion
        PUAS_RUN   = 4'h8  // Initialised
    } puas_state_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic       valid; // One-cycle write strobe
        logic [3:0] index; // Working register index
        logic [7:0] data;  // Value to store
    } puas_wr_s;

    typedef struct packed
    {
        logic       valid; // One-cycle address-match request
        logic       mgmt;  // 0 = I2C, 1 = management bus
        logic [6:0] addr;  // 7-bit address seen on the bus
    } puas_addr_s;

endpackage : puas_pkg

// *** logic/puas_strap_decode.sv ***
// Strap converter decoder: 10-bit reading to a 4-bit address offset,
// with a flag for an open (floating) strap.
// Assumes the code is stable while the caller samples the outputs.
`timescale 1ns/1ps
`default_nettype none
module puas_strap_decode
    import puas_pkg::*;
(
    input  wire logic [9:0] code_in,     // Converter reading
    output logic      [3:0] offset_out,  // Nearest band, 0..15
    output logic            floating_out // Reading above all bands
);

    // ------------------------------------------------------------------
    // Nearest-band decode
    // ------------------------------------------------------------------
    // Division by a constant band width keeps the table out of the code;
    // a reading past half a band above the top nominal is an open strap.
    logic [10:0] wide_code; // Reading widened for arithmetic
    logic [10:0] band;      // Rounded band number
    logic [10:0] top_limit; // Last code not treated as floating

    always_comb
    begin
        wide_code = {1'b0, code_in};
        top_limit = 11'(PUAS_STRAP_NOM0 + 11'(PUAS_STRAP_STEP * 11'h00f)
                        + PUAS_STRAP_HALF);
        if (wide_code <= PUAS_STRAP_NOM0)
        begin
            band = 11'h000;
        end
        else
        begin
            band = 11'((wide_code - PUAS_STRAP_NOM0 + PUAS_STRAP_HALF)
                       / PUAS_STRAP_STEP);
        end
        offset_out   = (band > 11'h00f) ? PUAS_STRAP_TOP : band[3:0];
        floating_out = (wide_code > top_limit);
    end

endmodule : puas_strap_decode
`default_nettype wire

// *** tb/puas_far_model.sv ***
// Far-side model: configuration memory and strap converter.
// Assumes the core asks for words by level and starts one conversion.
`timescale 1ns/1ps
`default_nettype none
module puas_far_model
(
    input  wire logic       mclk_in,   // Core clock
    input  wire logic       req_in,    // Word request level
    input  wire logic [3:0] index_in,  // Word wanted
    input  wire logic       start_in,  // Conversion start pulse
    input  wire logic [9:0] code_in,   // Reading to report
    input  wire logic [7:0] en_opt_in, // Contents of word 2
    input  wire logic       slow_in,   // Stall replies
    output logic            valid_out, // Word present
    output logic      [7:0] data_out,  // Word value
    output logic            done_out,  // Reading valid
    output logic      [9:0] code_out   // Converter output
);
    logic       phase_r = 1'b0;  // Alternates for slow replies
    logic [3:0] wait_r  = 4'h0;  // Conversion countdown
    logic       vld_r   = 1'b0;  // Reply strobe
    logic       done_r  = 1'b0;  // Reading strobe
    logic [7:0] word;            // Addressed word
    assign word = (index_in == 4'h0) ? 8'h12 : (index_in == 4'h1) ? 8'h45 :
                  (index_in == 4'h2) ? en_opt_in : 8'h30 + {4'h0, index_in};
    // Lines not qualified show the inverse, so stale values never pass
    assign valid_out = vld_r;
    assign data_out  = vld_r ? word : ~word;
    assign done_out  = done_r;
    assign code_out  = done_r ? code_in : ~code_in;
    // Replies change off the core's sampling edge
    always @(negedge mclk_in)
    begin
        phase_r <= ~phase_r;
        vld_r   <= req_in && !(slow_in && phase_r);
        if (start_in)
            wait_r <= slow_in ? 4'h6 : 4'h1;
        else if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
        done_r <= (wait_r == 4'h1);
    end
endmodule : puas_far_model
`default_nettype wire

// *** tb/puas_init_core_tb.sv ***
// Testbench of the initialisation core, sequences of port accesses.
// Assumes the far-side model answers memory and converter requests.
`timescale 1ns/1ps
`default_nettype none
module puas_init_core_tb
    import puas_pkg::*;
;
    logic mclk_in = 1'b0, reset_n_in = 1'b0;  // Clock and reset
    logic vcc_good_in = 1'b0, core_rail_good_in = 1'b0, osc_stable_in = 1'b0;
    logic enable_input_pin_in = 1'b0, bus_supply_ok_in = 1'b0, slow = 1'b0;
    logic [9:0] code = 10'h000;                // Strap reading to model
    logic [7:0] en_opt = 8'h00;                // Word 2 contents
    logic [3:0] rd_index_in = 4'h0;            // Read index
    puas_wr_s   wr_in = '0;                    // Write request
    puas_addr_s addr_in = '0;                  // Match request
    logic cfg_rd_req_out, cfg_rd_valid_in, adc_start_out, adc_done_in;
    logic [3:0] cfg_rd_index_out, addr_offset_out;
    logic [7:0] cfg_rd_data_in, rd_data_out;
    logic [9:0] adc_code_in;
    logic addr_ack_out, wr_refused_out, internal_reset_n_out, init_done_out;
    logic analog_mode_out, conv_en_out;
    logic [2:0] pins_analog_out;
    logic [6:0] i2c_address_out, mgmt_address_out;
    int error_cnt = 0, n_checks = 0, starts = 0, i;
    // Short load keeps each boot brief; four words still cover the map
    puas_init_core #(.CFG_WORDS(4)) puas_init_core_inst (.*);
    puas_far_model puas_far_model_inst (.mclk_in, .req_in(cfg_rd_req_out),
        .index_in(cfg_rd_index_out), .start_in(adc_start_out),
        .code_in(code), .en_opt_in(en_opt), .slow_in(slow),
        .valid_out(cfg_rd_valid_in), .data_out(cfg_rd_data_in),
        .done_out(adc_done_in), .code_out(adc_code_in));
    initial forever #2.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) starts += adc_start_out;
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n = 1);
        repeat (n) @(negedge mclk_in);
    endtask : step
    // Drop supplies, raise them, wait for the sequence to finish
    task automatic boot(input logic [9:0] c, input logic s);
        int n;
        code = c; slow = s; {vcc_good_in, core_rail_good_in} = 2'h0;
        step(2);
        starts = 0; n = 0; {vcc_good_in, core_rail_good_in} = 2'h3;
        while (init_done_out !== 1'b1 && n < 200)
        begin
            if (cfg_rd_req_out === 1'b1) chk(init_done_out, 0);
            step(); n++;
        end
        chk(n < 200, 1); step(2);
        chk(starts, 1);
        chk(internal_reset_n_out, 1);
    endtask : boot
    task automatic rd(input logic [3:0] idx, input logic [7:0] e);
        rd_index_in = idx; step(); chk(rd_data_out, e);
    endtask : rd
    task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic e);
        wr_in = '{1'b1, idx, d}; step(); chk(wr_refused_out, e);
        wr_in = '0; step();
    endtask : wr
    task automatic ack(input logic m, input logic [6:0] a, input logic e);
        addr_in = '{1'b1, m, a}; step(); chk(addr_ack_out, e);
        addr_in = '0; step();
    endtask : ack
    initial
    begin
        step(5); reset_n_in = 1'b1; step(3);
        chk(internal_reset_n_out, 0);
        rd(4'h0, PUAS_I2C_BASE_RST);
        rd(4'h1, PUAS_MGMT_BASE_RST);
        vcc_good_in = 1'b1; core_rail_good_in = 1'b1; step(3);
        chk({internal_reset_n_out, cfg_rd_req_out}, 0);
        osc_stable_in = 1'b1;
        // Every band nominal, alternating prompt and stalling replies
        for (i = 0; i < 16; i++)
        begin
            boot(10'd32 + 10'(60 * i), i[0]);
            chk(addr_offset_out, i);
            chk(i2c_address_out, 7'h12 + 7'(i));
            chk(mgmt_address_out, 7'h45 + 7'(i));
        end
        boot(10'd61, 0); chk(addr_offset_out, 0);
        boot(10'd63, 0); chk(addr_offset_out, 1);
        boot(10'd962, 0); chk({analog_mode_out, addr_offset_out}, 15);
        boot(10'd212, 0);
        rd(4'h0, 8'h12); rd(4'h1, 8'h45); rd(4'h3, 8'h33);
        ack(0, 7'h15, 1); ack(1, 7'h48, 1); ack(0, 7'h12, 0);
        ack(1, 7'h15, 0);
        bus_supply_ok_in = 1'b1; step(2); chk(conv_en_out, 0);
        enable_input_pin_in = 1'b1; step(2); chk(conv_en_out, 1);
        bus_supply_ok_in = 1'b0; step(2); chk(conv_en_out, 0);
        enable_input_pin_in = 1'b0;
        wr(4'h2, 8'h03, 0); step(2); chk(conv_en_out, 1);
        wr(4'h2, 8'h01, 0); step(2); chk(conv_en_out, 0);
        wr(4'h0, 8'h00, 0); step(2); chk(i2c_address_out, 0);
        ack(0, 7'h03, 0); ack(0, 7'h00, 0); ack(1, 7'h48, 1);
        wr(4'h4, 8'h55, 1); rd(4'h4, 8'h00);
        code = 10'h000; step(3); chk(addr_offset_out, 3);
        boot(10'd1000, 0);
        chk({analog_mode_out, pins_analog_out}, 4'hf);
        ack(1, 7'h54, 0);
        wr(4'h1, 8'h20, 1); rd(4'h1, 8'h45);
        tally_and_finish();
    end
    initial
    begin
        #50us;
        error_cnt++;
        tally_and_finish();
    end
endmodule : puas_init_core_tb
`default_nettype wire
